//--- include/tisc_pkg.sv
// Purpose: Shared constants, types and register map of the timer, interrupt and sleep control core
// Assumes: 8-bit register file access from the processor core, one clock at 20 MHz
// Notes:   Register offsets, fields, reset values, opcodes and timing follow
package tisc_pkg;

	// Register offsets
	localparam logic [7:0] OFS_TIMER_MODE  = 8'hf1;
	localparam logic [7:0] OFS_COUNT_B     = 8'hf2;
	localparam logic [7:0] OFS_PRESCALE_B  = 8'hf3;
	localparam logic [7:0] OFS_COUNT_A     = 8'hf4;
	localparam logic [7:0] OFS_PRESCALE_A  = 8'hf5;
	localparam logic [7:0] OFS_PORT2_DIR   = 8'hf6;
	localparam logic [7:0] OFS_IRQ_PRIO    = 8'hf9;
	localparam logic [7:0] OFS_IRQ_PEND    = 8'hfa;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'hfb;

	// Field positions
	localparam int TMR_LOAD_A  = 0;
	localparam int TMR_RUN_A   = 1;
	localparam int TMR_LOAD_B  = 2;
	localparam int TMR_RUN_B   = 3;
	localparam int TMR_TIN_LO  = 4;
	localparam int PRE_SRC_INT = 0;
	localparam int PRE_CONT    = 1;
	localparam int PRE_DIV_LO  = 2;
	localparam int IMR_GLOBAL  = 7;
	localparam int P2M_WAKE    = 7;
	localparam int NUM_LINES   = 6;

	// Reset values
	localparam logic [7:0] RST_TIMER_MODE = 8'h00;
	localparam logic [7:0] RST_PRESCALE   = 8'h00;
	localparam logic [7:0] RST_PORT2_DIR  = 8'hff;
	localparam logic [7:0] RST_IRQ        = 8'h00;
	localparam logic [7:0] RST_COUNT      = 8'h00;

	// Opcodes and addresses
	localparam logic [7:0]  OP_NOOP      = 8'hff;
	localparam logic [7:0]  OP_STOP      = 8'h6f;
	localparam logic [7:0]  OP_HALT      = 8'h7f;
	localparam logic [7:0]  OP_WDT_CLEAR = 8'h5f;
	localparam logic [15:0] RESTART_ADDR = 16'h000c;

	// Timing
	localparam int CLK_PERIOD_NS    = 50;
	localparam int INT_DIVIDE       = 4;
	localparam int POR_EXTRA_CYCLES = 18;
	localparam int WDT_PERIOD_US    = 1000;
	localparam int WDT_CYCLES       = (WDT_PERIOD_US * 1000) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		TIN_EXT_CLK     = 2'b00,
		TIN_GATE        = 2'b01,
		TIN_TRIG_ONCE   = 2'b10,
		TIN_TRIG_RETRIG = 2'b11
	} tisc_tin_t;

	typedef enum logic [1:0] {
		PWR_RUN  = 2'b00,
		PWR_HALT = 2'b01,
		PWR_STOP = 2'b10
	} tisc_pwr_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tisc_reg_req_t;

	typedef struct packed {
		logic z;
		logic s;
		logic v;
	} tisc_flags_t;

endpackage : tisc_pkg

//--- core/tisc_down_counter.sv
// Purpose: Prescaled down-counter used for both timers
// Assumes: tick is a one-cycle pulse from the selected source
// Notes:   A zero preset or initial value counts the full range
`timescale 1ns/1ps
`default_nettype none
module tisc_down_counter #(
	parameter int CNT_W = 8,
	parameter int PRE_W = 6
) (
	// Clock and resets
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             softRst,
	// Control
	input  wire logic             tick,
	input  wire logic             load,
	input  wire logic             run,
	input  wire logic             cont,
	input  wire logic [PRE_W-1:0] preset,
	input  wire logic [CNT_W-1:0] initVal,
	// Status
	output logic      [CNT_W-1:0] count,
	output logic                  endPulse
);
	localparam logic [PRE_W-1:0] PRE_ONE = PRE_W'(1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic done;
	logic [PRE_W-1:0] preCnt;
	logic step;
	logic hitEnd;

	// Prescaler end and counter end coincide for the request
	assign step   = run && !done && tick && !load;
	assign hitEnd = step && (preCnt == PRE_ONE) && (count == CNT_ONE);

	// Zero wraps to all ones, so preset 0 divides by 64 and count 0 gives 256
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count  <= '0;
			preCnt <= '0;
			done   <= 1'b0;
		end else if (softRst) begin
			count  <= '0;
			preCnt <= '0;
			done   <= 1'b0;
		end else if (load) begin
			count  <= initVal;
			preCnt <= preset;
			done   <= 1'b0;
		end else if (step) begin
			if (preCnt == PRE_ONE) begin
				preCnt <= preset;
				if (count == CNT_ONE) begin
					count <= cont ? initVal : '0;
					done  <= !cont;
				end else begin
					count <= count - CNT_ONE;
				end
			end else begin
				preCnt <= preCnt - PRE_ONE;
			end
		end
	end

	// End of count pulse
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			endPulse <= 1'b0;
		end else begin
			endPulse <= hitEnd && !softRst;
		end
	end

endmodule : tisc_down_counter
`default_nettype wire

//--- core/tisc_ctrl.sv
// Purpose: Timers, interrupt latching and priority, halt/stop sleep and watchdog
// Assumes: Core presents register accesses and executed opcodes on clk
// Notes:   Pins pass two flip-flops before any logic reads them
`timescale 1ns/1ps
`default_nettype none
module tisc_ctrl
	import tisc_pkg::*;
#(
	parameter int WDT_LIMIT = WDT_CYCLES,
	parameter int POR_HOLD  = POR_EXTRA_CYCLES
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          sys_rst,
	// Register file access
	input  wire tisc_reg_req_t regReq,
	output logic [7:0]         regRdData,
	output logic               regRdValid,
	// Executed opcode stream
	input  wire logic          execValid,
	input  wire logic [7:0]    execOpcode,
	// Interrupt handshake
	output logic               intReq,
	output logic [3:0]         intVector,
	input  wire logic          intAck,
	output logic               ctxSave,
	// Flags update
	output logic               flagWr,
	output tisc_flags_t        flagVal,
	// Sleep and restart
	output logic               cpuClkEn,
	output logic               oscEn,
	output logic               pcLoad,
	output logic [15:0]        pcLoadAddr,
	output logic               coreRst,
	output logic [7:0]         port2Dir,
	// Pins
	input  wire logic          analog_in_one,
	input  wire logic          analog_in_two,
	input  wire logic          ref_in,
	input  wire logic          ext_timer_in,
	input  wire logic          wake_pin
);
	localparam int WDT_W  = $clog2(WDT_LIMIT + 1) + 1;
	localparam int HOLD_W = $clog2(POR_HOLD + 1) + 1;
	localparam logic [WDT_W-1:0]  WDT_LAST = WDT_W'(WDT_LIMIT - 1);
	localparam logic [HOLD_W-1:0] HOLD_SET = HOLD_W'(POR_HOLD);
	localparam logic [2:0] LINES = 3'(NUM_LINES);

	// Register storage
	logic [7:0] timerMode;
	logic [7:0] preA;
	logic [7:0] preB;
	logic [7:0] initA;
	logic [7:0] initB;
	logic [7:0] irqPrio;
	logic [7:0] irqMask;
	logic [5:0] irqPend;

	// Pin synchronisers
	logic [4:0] pinMeta;
	logic [4:0] pinSync;
	logic [4:0] pinPrev;
	logic [4:0] pinFall;
	logic [4:0] pinRise;

	// Timer plumbing
	logic [1:0] divCnt;
	logic       divTick;
	logic [7:0] countA;
	logic [7:0] countB;
	logic       endA;
	logic       endB;
	logic       loadA;
	logic       loadB;
	logic       trigLoadB;
	logic       trigActive;
	logic       tickB;
	logic       runB;
	logic       bInternal;
	tisc_tin_t  tinMode;

	// Interrupt plumbing
	logic [5:0] srcEvent;
	logic [5:0] ackClr;
	logic [5:0] armed;
	logic [2:0] selIdx;
	logic       found;
	logic [2:0] ackIdx;

	// Power and watchdog
	tisc_pwr_t           pwr;
	tisc_pwr_t           next_pwr;
	logic [WDT_W-1:0]    wdtCnt;
	logic [HOLD_W-1:0]   holdCnt;
	logic                ctlRst;
	logic                opStop;
	logic                opHalt;
	logic                opWdt;
	logic                wakeOk;
	logic                wr;

	assign wr     = regReq.wr;
	assign ctlRst = (holdCnt != '0);
	assign opStop = execValid && (execOpcode == OP_STOP) && (pwr == PWR_RUN);
	assign opHalt = execValid && (execOpcode == OP_HALT) && (pwr == PWR_RUN);
	assign opWdt  = execValid && (execOpcode == OP_WDT_CLEAR);

	// Two flops on each pin; reset at the idle high level so release fakes no edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinMeta <= '1;
			pinSync <= '1;
			pinPrev <= '1;
		end else begin
			pinMeta <= {wake_pin, ext_timer_in, ref_in, analog_in_two, analog_in_one};
			pinSync <= pinMeta;
			pinPrev <= pinSync;
		end
	end

	assign pinFall = pinPrev & ~pinSync;
	assign pinRise = ~pinPrev & pinSync;

	// Internal source divided by four; frozen while the oscillator is off
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			divCnt <= '0;
		end else if (pwr != PWR_STOP) begin
			divCnt <= divCnt + 2'b01;
		end
	end

	assign divTick = (divCnt == 2'(INT_DIVIDE - 1)) && (pwr != PWR_STOP);

	// Timer mode register; load bits act once and read back as zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			timerMode <= RST_TIMER_MODE;
		end else if (ctlRst) begin
			timerMode <= RST_TIMER_MODE;
		end else if (wr && regReq.addr == OFS_TIMER_MODE) begin
			timerMode <= regReq.wdata & ~8'h05;
		end
	end

	// Prescaler and initial count registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			preA  <= RST_PRESCALE;
			preB  <= RST_PRESCALE;
			initA <= RST_COUNT;
			initB <= RST_COUNT;
		end else if (ctlRst) begin
			preA  <= RST_PRESCALE;
			preB  <= RST_PRESCALE;
			initA <= RST_COUNT;
			initB <= RST_COUNT;
		end else if (wr) begin
			case (regReq.addr)
				OFS_PRESCALE_A: preA  <= regReq.wdata;
				OFS_PRESCALE_B: preB  <= regReq.wdata;
				OFS_COUNT_A:    initA <= regReq.wdata;
				OFS_COUNT_B:    initB <= regReq.wdata;
				default:        initA <= initA;
			endcase
		end
	end

	// Software load strobes restart from the initial value
	assign loadA = wr && (regReq.addr == OFS_TIMER_MODE) && regReq.wdata[TMR_LOAD_A];
	assign loadB = (wr && (regReq.addr == OFS_TIMER_MODE) && regReq.wdata[TMR_LOAD_B])
		|| trigLoadB;

	// Timer_b source and external input use
	assign bInternal = preB[PRE_SRC_INT];
	assign tinMode   = tisc_tin_t'(timerMode[TMR_TIN_LO +: 2]);

	always_comb begin
		tickB = 1'b0;
		if (!bInternal) begin
			tickB = pinFall[3];
		end else if (tinMode == TIN_GATE) begin
			tickB = divTick && pinSync[3];
		end else begin
			tickB = divTick;
		end
	end

	// A trigger that arrives while a single trigger runs is ignored
	assign trigLoadB = bInternal && pinFall[3] && (pwr != PWR_STOP)
		&& ((tinMode == TIN_TRIG_RETRIG)
		|| (tinMode == TIN_TRIG_ONCE && !trigActive));

	// Trigger modes only count after an accepted trigger
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trigActive <= 1'b0;
		end else if (ctlRst) begin
			trigActive <= 1'b0;
		end else if (trigLoadB) begin
			trigActive <= 1'b1;
		end else if (endB && !preB[PRE_CONT]) begin
			trigActive <= 1'b0;
		end
	end

	assign runB = timerMode[TMR_RUN_B] && (!bInternal || tinMode == TIN_EXT_CLK
		|| tinMode == TIN_GATE || trigActive);

	// Timer_a: internal source only
	tisc_down_counter #(
		.CNT_W (8),
		.PRE_W (6)
	) u_timer_a (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.softRst  (ctlRst),
		.tick     (divTick),
		.load     (loadA),
		.run      (timerMode[TMR_RUN_A]),
		.cont     (preA[PRE_CONT]),
		.preset   (preA[PRE_DIV_LO +: 6]),
		.initVal  (initA),
		.count    (countA),
		.endPulse (endA)
	);

	// Timer_b: internal or external source
	tisc_down_counter #(
		.CNT_W (8),
		.PRE_W (6)
	) u_timer_b (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.softRst  (ctlRst),
		.tick     (tickB),
		.load     (loadB),
		.run      (runB),
		.cont     (preB[PRE_CONT]),
		.preset   (preB[PRE_DIV_LO +: 6]),
		.initVal  (initB),
		.count    (countB),
		.endPulse (endB)
	);

	// Request sources; no clock reaches the edge logic in stop
	assign srcEvent = {endB, endA, pinRise[1], pinFall[0], pinFall[2], pinFall[1]}
		& {6{pwr != PWR_STOP}};

	// Line taken by the core is cleared on its acknowledge
	assign ackClr = (intAck) ? (6'b000001 << ackIdx) : 6'b000000;

	// Pending register: events win over clears, masks do not block latching
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqPend <= RST_IRQ[5:0];
		end else if (ctlRst) begin
			irqPend <= RST_IRQ[5:0];
		end else if (wr && regReq.addr == OFS_IRQ_PEND) begin
			irqPend <= (regReq.wdata[5:0] & ~ackClr) | srcEvent;
		end else begin
			irqPend <= (irqPend & ~ackClr) | srcEvent;
		end
	end

	// Mask register; the global enable drops when a request is granted
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqMask <= RST_IRQ;
		end else if (ctlRst) begin
			irqMask <= RST_IRQ;
		end else if (wr && regReq.addr == OFS_IRQ_MASK) begin
			irqMask <= regReq.wdata;
		end else if (intAck) begin
			irqMask[IMR_GLOBAL] <= 1'b0;
		end
	end

	// Priority register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqPrio <= RST_IRQ;
		end else if (ctlRst) begin
			irqPrio <= RST_IRQ;
		end else if (wr && regReq.addr == OFS_IRQ_PRIO) begin
			irqPrio <= regReq.wdata;
		end
	end

	assign armed = irqPend & irqMask[5:0] & {6{irqMask[IMR_GLOBAL]}};

	// Rotating search starting at the line named by the priority register
	always_comb begin
		logic [2:0] start;
		logic [2:0] cand;
		start  = (irqPrio[2:0] < LINES) ? irqPrio[2:0] : 3'b000;
		cand   = 3'b000;
		selIdx = 3'b000;
		found  = 1'b0;
		for (int k = 0; k < NUM_LINES; k++) begin
			cand = start + 3'(k);
			if (cand >= LINES) begin
				cand = cand - LINES;
			end
			if (!found && armed[cand]) begin
				selIdx = cand;
				found  = 1'b1;
			end
		end
	end

	// Request and vector are registered together so they always agree
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			intReq    <= 1'b0;
			intVector <= '0;
			ackIdx    <= '0;
			ctxSave   <= 1'b0;
		end else begin
			intReq    <= found && !intAck && !ctlRst && (pwr != PWR_STOP);
			intVector <= {selIdx, 1'b0};
			ackIdx    <= selIdx;
			ctxSave   <= intAck;
		end
	end

	// Wake from stop needs the wake pin set as input and driven low
	assign wakeOk = !pinSync[4] && port2Dir[P2M_WAKE];

	always_comb begin
		next_pwr = pwr;
		case (pwr)
			PWR_RUN: begin
				if (opStop) begin
					next_pwr = PWR_STOP;
				end else if (opHalt) begin
					next_pwr = PWR_HALT;
				end
			end
			PWR_HALT: begin
				if (found) begin
					next_pwr = PWR_RUN;
				end
			end
			PWR_STOP: begin
				if (wakeOk) begin
					next_pwr = PWR_RUN;
				end
			end
			default: next_pwr = PWR_RUN;
		endcase
	end

	// Power state; a watchdog reset always returns to run
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwr <= PWR_RUN;
		end else if (ctlRst) begin
			pwr <= PWR_RUN;
		end else begin
			pwr <= next_pwr;
		end
	end

	// Clock gates and restart request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cpuClkEn   <= 1'b1;
			oscEn      <= 1'b1;
			pcLoad     <= 1'b0;
			pcLoadAddr <= '0;
		end else begin
			cpuClkEn   <= (next_pwr == PWR_RUN) || ctlRst;
			oscEn      <= (next_pwr != PWR_STOP) || ctlRst;
			pcLoad     <= (pwr == PWR_STOP) && wakeOk && !ctlRst;
			pcLoadAddr <= RESTART_ADDR;
		end
	end

	// Port direction survives a stop wake; only resets restore inputs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			port2Dir <= RST_PORT2_DIR;
		end else if (ctlRst) begin
			port2Dir <= RST_PORT2_DIR;
		end else if (wr && regReq.addr == OFS_PORT2_DIR) begin
			port2Dir <= regReq.wdata;
		end
	end

	// Watchdog runs unconditionally except with the oscillator off
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wdtCnt <= '0;
		end else if (ctlRst || opWdt) begin
			wdtCnt <= '0;
		end else if (pwr != PWR_STOP) begin
			wdtCnt <= wdtCnt + WDT_W'(1);
		end
	end

	// Reset stretch after power-on and after each watchdog expiry
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			holdCnt <= HOLD_SET;
		end else if (wdtCnt == WDT_LAST && !ctlRst) begin
			holdCnt <= HOLD_SET;
		end else if (holdCnt != '0) begin
			holdCnt <= holdCnt - HOLD_W'(1);
		end
	end

	// Core held in reset while the stretch runs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			coreRst <= 1'b1;
		end else begin
			coreRst <= (holdCnt > HOLD_W'(1)) || (wdtCnt == WDT_LAST && !ctlRst);
		end
	end

	// Flag update that accompanies the watchdog clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flagWr  <= 1'b0;
			flagVal <= '0;
		end else begin
			flagWr  <= opWdt && !ctlRst;
			flagVal <= '{z: 1'b1, s: 1'b0, v: 1'b0};
		end
	end

	// Read port; write-only and unmapped addresses read zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData  <= '0;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regReq.rd;
			if (regReq.rd) begin
				case (regReq.addr)
					OFS_TIMER_MODE: regRdData <= timerMode;
					OFS_COUNT_A:    regRdData <= countA;
					OFS_COUNT_B:    regRdData <= countB;
					OFS_IRQ_PEND:   regRdData <= {2'b00, irqPend};
					OFS_IRQ_MASK:   regRdData <= irqMask;
					default:        regRdData <= 8'h00;
				endcase
			end
		end
	end

endmodule : tisc_ctrl
`default_nettype wire

//--- verif/tisc_ctrl_asserts.sv
// Purpose: Port-level checker for the timer, interrupt and sleep control core
// Assumes: Bound to tisc_ctrl; one clock domain, reset high
// Notes:   The watchdog check is an upper bound, because the design's own count start is not visible
`timescale 1ns/1ps
`default_nettype none
module tisc_ctrl_asserts
	import tisc_pkg::*;
#(
	parameter int WDT_LIMIT = 300,
	parameter int POR_HOLD  = 4
) (
	// Clock and reset
	input wire logic          clk,
	input wire logic          sys_rst,
	// Core side
	input wire tisc_reg_req_t regReq,
	input wire logic          regRdValid,
	input wire logic          execValid,
	input wire logic [7:0]    execOpcode,
	input wire logic          intReq,
	input wire logic [3:0]    intVector,
	input wire logic          intAck,
	input wire logic          ctxSave,
	input wire logic          flagWr,
	input wire tisc_flags_t   flagVal,
	// Sleep and restart
	input wire logic          cpuClkEn,
	input wire logic          oscEn,
	input wire logic          pcLoad,
	input wire logic [15:0]   pcLoadAddr,
	input wire logic          coreRst,
	input wire logic [7:0]    port2Dir
);
	int   porCnt;
	int   wdCnt;
	logic porPhase;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Edges since reset release, only until the core is first let go
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			porCnt   <= 0;
			porPhase <= 1'b1;
		end else begin
			porCnt   <= porPhase ? porCnt + 1 : porCnt;
			porPhase <= porPhase && coreRst;
		end
	end

	// Running cycles without a clear; frozen while the oscillator is off
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			wdCnt <= 0;
		else if (coreRst || (execValid && execOpcode == OP_WDT_CLEAR))
			wdCnt <= 0;
		else if (oscEn)
			wdCnt <= wdCnt + 1;
	end

	sequence sWdClr;
		execValid && execOpcode == OP_WDT_CLEAR;
	endsequence
	sequence sSleep(op);
		execValid && execOpcode == op && cpuClkEn;
	endsequence

	a_read_answer: assert property (regReq.rd |=> regRdValid)
		else $error("read not answered next cycle");
	a_grant_save: assert property (intAck |=> ctxSave && !intReq)
		else $error("grant without context save");
	a_vector_pair: assert property (intReq |-> !intVector[0] && intVector < 4'hc)
		else $error("vector outside the six pairs");
	a_wdclr_flags: assert property (sWdClr |=> flagWr && flagVal == 3'b100)
		else $error("clear opcode flags wrong");
	a_halt_clock: assert property (sSleep(OP_HALT) |=> !cpuClkEn && oscEn)
		else $error("halt did not stop core clock only");
	a_stop_osc: assert property (sSleep(OP_STOP) |=> (!cpuClkEn && !oscEn) [*2])
		else $error("stop did not stop both clocks");
	a_wake_restart: assert property (pcLoad |-> pcLoadAddr == RESTART_ADDR && cpuClkEn
		&& oscEn && $stable(port2Dir))
		else $error("stop wake restart wrong");
	a_por_stretch: assert property ($fell(coreRst) && porPhase |-> porCnt == POR_HOLD)
		else $error("core reset stretch length wrong");
	a_wdt_bite: assert property (wdCnt <= WDT_LIMIT + 1)
		else $error("watchdog did not reset the core");
endmodule : tisc_ctrl_asserts
`default_nettype wire

bind tisc_ctrl tisc_ctrl_asserts #(.WDT_LIMIT(WDT_LIMIT), .POR_HOLD(POR_HOLD)) u_chk (
	.clk, .sys_rst, .regReq, .regRdValid, .execValid, .execOpcode, .intReq, .intVector,
	.intAck, .ctxSave, .flagWr, .flagVal, .cpuClkEn, .oscEn, .pcLoad, .pcLoadAddr,
	.coreRst, .port2Dir);

//--- verif/tisc_core_model.sv
// Purpose: Behavioural processor core facing the control block
// Assumes: Opcodes and grants change at the falling edge
// Notes:   Sends its own watchdog clears so long tests do not bite
`timescale 1ns/1ps
`default_nettype none
module tisc_core_model
	import tisc_pkg::*;
(
	// Status from the block
	input  wire logic clk,
	input  wire logic intReq,
	input  wire logic cpuClkEn,
	input  wire logic coreRst,
	// Core outputs
	output logic       execValid,
	output logic [7:0] execOpcode,
	output logic       intAck
);
	logic [7:0] opQ[$];
	logic       ackEn  = 1'b0;
	int         ackDly = 4;
	logic       wdOn   = 1'b1;
	int         ackCnt = 0;
	int         wdGap  = 0;

	// Sleep entry always flushes the pipeline first
	task automatic sleep(input logic [7:0] op);
		opQ.push_back(OP_NOOP);
		opQ.push_back(op);
	endtask : sleep

	// One opcode a cycle; grants wait ackDly cycles to mimic a slow core
	initial begin
		execValid  = 1'b0;
		execOpcode = OP_NOOP;
		intAck     = 1'b0;
		forever begin
			@(negedge clk);
			execValid = 1'b0;
			intAck    = 1'b0;
			if (opQ.size() > 0) begin
				execValid  = 1'b1;
				execOpcode = opQ.pop_front();
			end else if (wdOn && cpuClkEn && !coreRst) begin
				wdGap++;
				if (wdGap >= 100) begin
					wdGap      = 0;
					execValid  = 1'b1;
					execOpcode = OP_WDT_CLEAR;
				end
			end
			if (ackEn && intReq && cpuClkEn) begin
				if (ackCnt >= ackDly) begin
					intAck = 1'b1;
					ackCnt = 0;
				end else begin
					ackCnt++;
				end
			end else begin
				ackCnt = 0;
			end
		end
	end
endmodule : tisc_core_model
`default_nettype wire

//--- verif/timer_irq_sleep_ctrl_tb.sv
// Purpose: Self-checking bench for the timer, interrupt and sleep control core
// Assumes: Short reset stretch and watchdog period to keep the run brief
// Notes:   Register accesses take two cycles so strobes never change twice at once
`timescale 1ns/1ps
`default_nettype none
module timer_irq_sleep_ctrl_tb;
	import tisc_pkg::*;
	localparam int WDL = 300;
	localparam int PH  = 4;

	logic          clk;
	logic          sys_rst;
	tisc_reg_req_t regReq;
	logic [7:0]    regRdData;
	logic          regRdValid;
	logic          execValid;
	logic [7:0]    execOpcode;
	logic          intReq;
	logic [3:0]    intVector;
	logic          intAck;
	logic          ctxSave;
	logic          flagWr;
	tisc_flags_t   flagVal;
	logic          cpuClkEn;
	logic          oscEn;
	logic          pcLoad;
	logic [15:0]   pcLoadAddr;
	logic          coreRst;
	logic [7:0]    port2Dir;
	logic          analog_in_one;
	logic          analog_in_two;
	logic          ref_in;
	logic          ext_timer_in;
	logic          wake_pin;
	int            nFail = 0;
	int            cmpCount = 0;
	logic [7:0]    rstA[8] = '{8'hf1, 8'hf3, 8'hf5, 8'hf6, 8'hf9, 8'hfa, 8'hfb, 8'hf0};

	tisc_ctrl #(.WDT_LIMIT(WDL), .POR_HOLD(PH)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
		.regRdValid(regRdValid), .execValid(execValid), .execOpcode(execOpcode),
		.intReq(intReq), .intVector(intVector), .intAck(intAck), .ctxSave(ctxSave),
		.flagWr(flagWr), .flagVal(flagVal), .cpuClkEn(cpuClkEn), .oscEn(oscEn),
		.pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .coreRst(coreRst), .port2Dir(port2Dir),
		.analog_in_one(analog_in_one), .analog_in_two(analog_in_two), .ref_in(ref_in),
		.ext_timer_in(ext_timer_in), .wake_pin(wake_pin));

	tisc_core_model u_core (
		.clk(clk), .intReq(intReq), .cpuClkEn(cpuClkEn), .coreRst(coreRst),
		.execValid(execValid), .execOpcode(execOpcode), .intAck(intAck));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic wrapUp();
		$display("compares %0d mismatches %0d", cmpCount, nFail);
		if (nFail == 0 && cmpCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrapUp

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmpCount++;
		if (g !== e) begin
			nFail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regReq = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		regReq = '0;
	endtask : wr

	// Read answer stands one cycle, so it is looked at in that cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		regReq = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		regReq = '0;
		chk({regRdValid, regRdData}, {1'b1, e});
	endtask : rd

	function automatic logic pick(input int k);
		case (k)
			0: return intReq;
			1: return cpuClkEn;
			2: return pcLoad;
			3: return coreRst;
			4: return !coreRst;
			default: return flagWr;
		endcase
	endfunction : pick

	// Bounded wait; running out ends the run
	task automatic waitOn(input int k, input int lim, output int c);
		c = 0;
		while (pick(k) !== 1'b1) begin
			@(negedge clk);
			c++;
			if (c > lim) begin
				nFail++;
				$display("mismatch t=%0t wait=%h exp=%h", $time, k, 1);
				wrapUp();
			end
		end
	endtask : waitOn

	// Main sequence
	initial begin
		int c;
		int p;
		regReq = '0;
		{analog_in_one, analog_in_two, ref_in, ext_timer_in, wake_pin} = 5'h1f;
		sys_rst = 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		repeat (PH + 2) @(negedge clk);
		chk(port2Dir, 8'hff);
		foreach (rstA[i]) rd(rstA[i], 8'h00);
		wr(8'hfb, 8'h00);
		{analog_in_two, ref_in, analog_in_one} = 3'b000;
		repeat (5) @(negedge clk);
		analog_in_two = 1'b1;
		repeat (5) @(negedge clk);
		chk(intReq, 1'b0);
		rd(8'hfa, 8'h0f);
		u_core.ackEn = 1'b1;
		for (p = 0; p < 4; p++) begin
			wr(8'hfa, 8'h0f);
			wr(8'hf9, p[7:0]);
			wr(8'hfb, 8'h8f);
			repeat (2) @(negedge clk);
			chk({intReq, intVector}, {1'b1, 4'(2 * p)});
			repeat (8) @(negedge clk);
			rd(8'hfa, 8'h0f & ~(8'h01 << p));
			rd(8'hfb, 8'h0f);
		end
		wr(8'hfa, 8'h20);
		rd(8'hfa, 8'h20);
		wr(8'hfa, 8'h00);
		rd(8'hfa, 8'h00);
		// Timer a single pass: 3 counts of divide 2 on the clk/4 tick
		u_core.ackEn = 1'b0;
		wr(8'hfb, 8'h90);
		wr(8'hf5, 8'h08);
		wr(8'hf4, 8'h03);
		wr(8'hf1, 8'h03);
		waitOn(0, 40, c);
		chk(c >= 20 && c <= 30, 1'b1);
		chk(intVector, 4'h8);
		rd(8'hf4, 8'h00);
		// Timer b continuous reloads, timer a stays done
		wr(8'hfb, 8'h00);
		wr(8'hf3, 8'h0b);
		wr(8'hf2, 8'h02);
		wr(8'hf1, 8'h0c);
		rd(8'hf3, 8'h00);
		repeat (24) @(negedge clk);
		wr(8'hfa, 8'h00);
		repeat (24) @(negedge clk);
		rd(8'hfa, 8'h20);
		wr(8'hf1, 8'h00);
		// Timer b on external falling edges: the third edge ends a count of 3
		wr(8'hfa, 8'h00);
		wr(8'hf3, 8'h06);
		wr(8'hf2, 8'h03);
		wr(8'hf1, 8'h0c);
		repeat (2) begin
			ext_timer_in = 1'b0;
			repeat (3) @(negedge clk);
			ext_timer_in = 1'b1;
			repeat (3) @(negedge clk);
		end
		rd(8'hf2, 8'h01);
		ext_timer_in = 1'b0;
		repeat (6) @(negedge clk);
		rd(8'hfa, 8'h20);
		// Gate mode with the input held low: the count must not move
		wr(8'hf3, 8'h07);
		wr(8'hf1, 8'h1c);
		repeat (20) @(negedge clk);
		rd(8'hf2, 8'h03);
		// Halt, woken by an enabled pin request
		u_core.ackDly = 0;
		u_core.ackEn = 1'b1;
		wr(8'hfa, 8'h00);
		wr(8'hfb, 8'h81);
		u_core.sleep(OP_HALT);
		repeat (4) @(negedge clk);
		chk({cpuClkEn, oscEn}, 2'b01);
		analog_in_two = 1'b0;
		waitOn(1, 10, c);
		analog_in_two = 1'b1;
		// Stop, woken by the wake pin set as input
		wr(8'hf6, 8'h80);
		u_core.sleep(OP_STOP);
		repeat (4) @(negedge clk);
		chk({cpuClkEn, oscEn}, 2'b00);
		wake_pin = 1'b0;
		waitOn(2, 10, c);
		chk({pcLoadAddr, port2Dir}, {16'h000c, 8'h80});
		wake_pin = 1'b1;
		// Watchdog clear flags, then let it bite
		u_core.opQ.push_back(OP_WDT_CLEAR);
		waitOn(5, 5, c);
		chk(flagVal, 3'b100);
		u_core.wdOn = 1'b0;
		waitOn(3, WDL + 20, c);
		waitOn(4, PH + 4, c);
		chk(port2Dir, 8'hff);
		rd(8'hfb, 8'h00);
		wrapUp();
	end
endmodule : timer_irq_sleep_ctrl_tb
`default_nettype wire
